// >>> rtl/rpsk_pkg.sv
// shared constants for the pad skew configuration bank
package rpsk_pkg;
  // management register numbers of the indirect access portal
  localparam logic [4:0] REG_MMD_CTRL = 5'h0D;
  localparam logic [4:0] REG_MMD_DATA = 5'h0E;
  // portal control field layout
  localparam int FUNC_HI = 15;
  localparam int FUNC_LO = 14;
  localparam int DEVAD_HI = 4;
  localparam logic [1:0] FUNC_ADDRESS = 2'h0;
  localparam logic [4:0] MMD_DEV_SKEW = 5'h02;
  // skew register offsets inside the device
  localparam logic [15:0] OFS_CTL_SKEW = 16'h0004;
  localparam logic [15:0] OFS_RXD_SKEW = 16'h0005;
  localparam logic [15:0] OFS_TXD_SKEW = 16'h0006;
  localparam logic [15:0] OFS_CLK_SKEW = 16'h0008;
  // reset values
  localparam logic [15:0] RST_CTL_SKEW = 16'h0077;
  localparam logic [15:0] RST_RXD_SKEW = 16'h7777;
  localparam logic [15:0] RST_TXD_SKEW = 16'h7777;
  localparam logic [15:0] RST_CLK_SKEW = 16'h01EF;
  // writable bits; everything else is reserved
  localparam logic [15:0] MASK_CTL_SKEW = 16'h00FF;
  localparam logic [15:0] MASK_CLK_SKEW = 16'h03FF;
  // field positions
  localparam int CTL_RX_LO = 4;
  localparam int CTL_TX_LO = 0;
  localparam int CLK_TX_LO = 5;
  localparam int CLK_RX_LO = 0;
  localparam int CODE4_W = 4;
  localparam int CODE5_W = 5;
  // codes that mean no adjustment
  localparam logic [3:0] CODE4_ZERO = 4'h7;
  localparam logic [4:0] CODE5_ZERO = 5'h0F;
  // step size per code unit
  localparam int STEP_PS = 60;
  // width of the bundle carried to the link domain
  localparam int BUNDLE_W = 50;
  localparam logic [49:0] RST_BUNDLE = {RST_CLK_SKEW[9:0], RST_TXD_SKEW, RST_RXD_SKEW,
    RST_CTL_SKEW[7:0]};
endpackage

// >>> rtl/rpsk_word_cross.sv
// handshake crossing of one configuration word into the link domain
`timescale 1ns/1ps
module rpsk_word_cross #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_WORD = '0
) (
  input wire logic srcClk,
  input wire logic srcRst,
  input wire logic [WIDTH-1:0] srcWord,
  output logic srcBusy,
  input wire logic dstClk,
  input wire logic dstRst,
  output logic [WIDTH-1:0] dstWord
);
  logic [WIDTH-1:0] holdWord;
  logic reqTog;
  logic ackS1;
  logic ackS2;
  logic reqS1;
  logic reqS2;
  logic reqS3;

  // hold word stays frozen while busy, so the far side samples it safely
  always_ff @(posedge srcClk) begin
    if (srcRst) begin
      holdWord <= RESET_WORD;
      reqTog <= 1'b0;
      srcBusy <= 1'b0;
    end else if (!srcBusy && srcWord != holdWord) begin
      holdWord <= srcWord;
      reqTog <= ~reqTog;
      srcBusy <= 1'b1;
    end else if (srcBusy && ackS2 == reqTog) begin
      srcBusy <= 1'b0;
    end
  end

  always_ff @(posedge srcClk) begin
    if (srcRst) begin
      ackS1 <= 1'b0;
      ackS2 <= 1'b0;
    end else begin
      ackS1 <= reqS2;
      ackS2 <= ackS1;
    end
  end

  always_ff @(posedge dstClk) begin
    if (dstRst) begin
      reqS1 <= 1'b0;
      reqS2 <= 1'b0;
      reqS3 <= 1'b0;
    end else begin
      reqS1 <= reqTog;
      reqS2 <= reqS1;
      reqS3 <= reqS2;
    end
  end

  always_ff @(posedge dstClk) begin
    if (dstRst) begin
      dstWord <= RESET_WORD;
    end else if (reqS2 != reqS3) begin
      dstWord <= holdWord;
    end
  end

  // a pending change reaches the link side and is acknowledged in bounded time
  property p_busyEnds;
    @(posedge srcClk) disable iff (srcRst)
      $rose(srcBusy) |-> ##[2:40] !srcBusy;
  endproperty
  a_busyEnds: assert property (p_busyEnds) else $error("crossing never acknowledged");

  // the link copy only moves on a request edge
  property p_dstOnlyOnReq;
    @(posedge dstClk) disable iff (dstRst)
      !$stable(dstWord) && !$past(dstRst) |-> $past(reqS2 != reqS3);
  endproperty
  a_dstOnlyOnReq: assert property (p_dstOnlyOnReq) else $error("link copy moved alone");
endmodule

// >>> rtl/rpsk_pad_skew.sv
// per-pin pad skew register bank with indirect access and link-side delivery
// Operation
// - Device drives receive clock, control and four data lines toward the MAC.
// - Every interface pin has its own programmable delay code.
// - Timing holds only within the transmit group and within the receive group.
// - Register 4 holds receive control code 7:4, transmit control 3:0, reset 0111.
// - Register 5 holds receive data codes, bit 3 high nibble, each reset 0111.
// - Register 6 holds transmit data codes, bit 3 high nibble, each reset 0111.
// - Register 8 holds transmit clock 9:5 and receive clock 4:0, reset 01111.
// - Control and data codes are four bits; clock codes are five bits.
// - Each code unit moves pin delay about 0.06 ns; higher code, longer delay.
// - Five-bit code 01111 is neutral, spanning -0.90 to +0.96 ns linearly.
// - Four-bit code 0111 is neutral, spanning -0.42 to +0.48 ns linearly.
// - Skew registers are reached through portal registers Dh and Eh.
// - At gigabit speed nibbles move on both clock edges.
`timescale 1ns/1ps
module rpsk_pad_skew (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] mgmtAddr,
  input wire logic mgmtWrEn,
  input wire logic mgmtRdEn,
  input wire logic [15:0] mgmtWrData,
  output logic [15:0] mgmtRdData,
  output logic mgmtRdValid,
  output logic cfgBusy,
  input wire logic rxRefClk,
  input wire logic rxCtlRise,
  input wire logic rxCtlFall,
  input wire logic [3:0] rxDataRise,
  input wire logic [3:0] rxDataFall,
  output logic rxClkPin,
  output logic rxCtlPin,
  output logic [3:0] rxDataPin,
  output logic [rpsk_pkg::CODE4_W-1:0] rx_ctl_delay_code,
  output logic [rpsk_pkg::CODE4_W-1:0] txCtlDelayCode,
  output logic [15:0] rxDataDelayCodes,
  output logic [15:0] txDataDelayCodes,
  output logic [rpsk_pkg::CODE5_W-1:0] tx_clock_delay_code,
  output logic [rpsk_pkg::CODE5_W-1:0] rxClockDelayCode,
  output logic signed [5:0] rxClockSteps,
  output logic signed [5:0] txClockSteps,
  output logic signed [4:0] rxCtlSteps
);
  import rpsk_pkg::*;

  logic [15:0] portalCtrl;
  logic [15:0] portalAddr;
  logic [15:0] controlSignalSkew;
  logic [15:0] receiveDataSkew;
  logic [15:0] transmitDataSkew;
  logic [15:0] clockSkew;
  logic dataMode;
  logic devHit;
  logic [15:0] selValue;
  logic selKnown;
  logic dataWrite;
  logic linkRstMeta;
  logic linkRst;
  logic [BUNDLE_W-1:0] coreBundle;
  logic [BUNDLE_W-1:0] linkBundle;
  logic rxCtlR;
  logic rxCtlF;
  logic [3:0] rxDataR;
  logic [3:0] rxDataF;
  logic [3:0] rx_bit3_delay_code;
  logic [3:0] tx_bit3_delay_code;

  // portal decode: function field picks address or data access
  assign dataMode = portalCtrl[FUNC_HI:FUNC_LO] != FUNC_ADDRESS;
  assign devHit = portalCtrl[DEVAD_HI:0] == MMD_DEV_SKEW;
  assign dataWrite = mgmtWrEn && mgmtAddr == REG_MMD_DATA && dataMode && devHit;

  // selected skew register; unknown offsets read zero
  always_comb begin
    selValue = 16'h0000;
    selKnown = 1'b1;
    unique case (portalAddr)
      OFS_CTL_SKEW: selValue = controlSignalSkew;
      OFS_RXD_SKEW: selValue = receiveDataSkew;
      OFS_TXD_SKEW: selValue = transmitDataSkew;
      OFS_CLK_SKEW: selValue = clockSkew;
      default: selKnown = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      portalCtrl <= 16'h0000;
    end else if (mgmtWrEn && mgmtAddr == REG_MMD_CTRL) begin
      portalCtrl <= mgmtWrData;
    end
  end

  // in address mode the data port stores the register offset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      portalAddr <= 16'h0000;
    end else if (mgmtWrEn && mgmtAddr == REG_MMD_DATA && !dataMode) begin
      portalAddr <= mgmtWrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      controlSignalSkew <= RST_CTL_SKEW;
    end else if (dataWrite && portalAddr == OFS_CTL_SKEW) begin
      controlSignalSkew <= mgmtWrData & MASK_CTL_SKEW;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      receiveDataSkew <= RST_RXD_SKEW;
    end else if (dataWrite && portalAddr == OFS_RXD_SKEW) begin
      receiveDataSkew <= mgmtWrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      transmitDataSkew <= RST_TXD_SKEW;
    end else if (dataWrite && portalAddr == OFS_TXD_SKEW) begin
      transmitDataSkew <= mgmtWrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      clockSkew <= RST_CLK_SKEW;
    end else if (dataWrite && portalAddr == OFS_CLK_SKEW) begin
      clockSkew <= mgmtWrData & MASK_CLK_SKEW;
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mgmtRdData <= 16'h0000;
      mgmtRdValid <= 1'b0;
    end else begin
      mgmtRdValid <= mgmtRdEn;
      if (mgmtRdEn) begin
        unique case (mgmtAddr)
          REG_MMD_CTRL: mgmtRdData <= portalCtrl;
          REG_MMD_DATA: mgmtRdData <= !dataMode ? portalAddr :
            ((devHit && selKnown) ? selValue : 16'h0000);
          default: mgmtRdData <= 16'h0000;
        endcase
      end
    end
  end

  // link-side reset follows the core reset through two flops
  always_ff @(posedge rxRefClk) begin
    linkRstMeta <= rst;
    linkRst <= linkRstMeta;
  end

  // codes are static pad controls, so one handshake for the whole set is enough
  assign coreBundle = {clockSkew[9:0], transmitDataSkew, receiveDataSkew,
    controlSignalSkew[7:0]};

  rpsk_word_cross #(
    .WIDTH(BUNDLE_W),
    .RESET_WORD(RST_BUNDLE)
  ) u_cross (
    .srcClk(core_clk),
    .srcRst(rst),
    .srcWord(coreBundle),
    .srcBusy(cfgBusy),
    .dstClk(rxRefClk),
    .dstRst(linkRst),
    .dstWord(linkBundle)
  );

  // unpack per-pin codes in the link domain
  assign tx_clock_delay_code = linkBundle[40+CLK_TX_LO +: CODE5_W];
  assign rxClockDelayCode = linkBundle[40+CLK_RX_LO +: CODE5_W];
  assign txDataDelayCodes = linkBundle[39:24];
  assign rxDataDelayCodes = linkBundle[23:8];
  assign rx_ctl_delay_code = linkBundle[CTL_RX_LO +: CODE4_W];
  assign txCtlDelayCode = linkBundle[CTL_TX_LO +: CODE4_W];
  assign rx_bit3_delay_code = rxDataDelayCodes[15:12];
  assign tx_bit3_delay_code = txDataDelayCodes[15:12];

  // signed steps of STEP_PS each, zero at the neutral code
  assign rxClockSteps = $signed({1'b0, rxClockDelayCode}) - $signed({1'b0, CODE5_ZERO});
  assign txClockSteps = $signed({1'b0, tx_clock_delay_code}) - $signed({1'b0, CODE5_ZERO});
  assign rxCtlSteps = $signed({1'b0, rx_ctl_delay_code}) - $signed({1'b0, CODE4_ZERO});

  // receive group: both halves registered together so the group stays aligned
  always_ff @(posedge rxRefClk) begin
    if (linkRst) begin
      rxCtlR <= 1'b0;
      rxCtlF <= 1'b0;
      rxDataR <= 4'h0;
      rxDataF <= 4'h0;
    end else begin
      rxCtlR <= rxCtlRise;
      rxCtlF <= rxCtlFall;
      rxDataR <= rxDataRise;
      rxDataF <= rxDataFall;
    end
  end

  // double data rate pins: high phase shows rise half, low phase the fall half
  assign rxClkPin = rxRefClk;
  assign rxCtlPin = rxRefClk ? rxCtlR : rxCtlF;
  assign rxDataPin = rxRefClk ? rxDataR : rxDataF;

  sequence s_portalSel(logic [15:0] ofs);
    mgmtWrEn && mgmtAddr == REG_MMD_DATA && !dataMode && mgmtWrData == ofs;
  endsequence

  sequence s_dataWrite;
    mgmtWrEn && mgmtAddr == REG_MMD_DATA && dataMode && devHit;
  endsequence

  sequence s_ctrlWrite;
    mgmtWrEn && mgmtAddr == REG_MMD_CTRL;
  endsequence

  sequence s_addrWrite;
    mgmtWrEn && mgmtAddr == REG_MMD_DATA && !dataMode;
  endsequence

  property p_ctlReset;
    @(posedge core_clk) rst |=> controlSignalSkew == RST_CTL_SKEW;
  endproperty
  a_ctlReset: assert property (p_ctlReset) else $error("control skew reset wrong");

  property p_rxdReset;
    @(posedge core_clk) rst |=> receiveDataSkew == RST_RXD_SKEW;
  endproperty
  a_rxdReset: assert property (p_rxdReset) else $error("rx data skew reset wrong");

  property p_txdReset;
    @(posedge core_clk) rst |=> transmitDataSkew == RST_TXD_SKEW;
  endproperty
  a_txdReset: assert property (p_txdReset) else $error("tx data skew reset wrong");

  property p_clkReset;
    @(posedge core_clk) rst |=> clockSkew == RST_CLK_SKEW;
  endproperty
  a_clkReset: assert property (p_clkReset) else $error("clock skew reset wrong");

  property p_reservedZero;
    @(posedge core_clk) disable iff (rst)
      controlSignalSkew[15:8] == 8'h00 && clockSkew[15:10] == 6'h00;
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bits set");

  property p_clkWriteLands;
    @(posedge core_clk) disable iff (rst)
      s_portalSel(OFS_CLK_SKEW) ##1 !mgmtWrEn ##1 s_ctrlWrite ##1 !mgmtWrEn ##1 s_dataWrite
      |=> clockSkew == ($past(mgmtWrData) & MASK_CLK_SKEW);
  endproperty
  a_clkWriteLands: assert property (p_clkWriteLands) else $error("clock skew write lost");

  property p_dataReadBack;
    @(posedge core_clk) disable iff (rst)
      mgmtRdEn && mgmtAddr == REG_MMD_DATA && dataMode && devHit
        && portalAddr == OFS_RXD_SKEW
      |=> mgmtRdValid && mgmtRdData == $past(receiveDataSkew);
  endproperty
  a_dataReadBack: assert property (p_dataReadBack) else $error("portal read wrong");

  property p_otherDevIgnored;
    @(posedge core_clk) disable iff (rst)
      mgmtWrEn && mgmtAddr == REG_MMD_DATA && dataMode && !devHit |=> $stable(clockSkew)
        && $stable(controlSignalSkew) && $stable(receiveDataSkew)
        && $stable(transmitDataSkew);
  endproperty
  a_otherDevIgnored: assert property (p_otherDevIgnored) else $error("foreign device write");

  property p_neutralSteps;
    @(posedge rxRefClk) disable iff (linkRst)
      (rxClockDelayCode == 5'h0F |-> rxClockSteps == 6'sh00)
        and (rx_ctl_delay_code == 4'hF |-> rxCtlSteps == 5'sh08)
        and (tx_clock_delay_code == 5'h1F |-> txClockSteps == 6'sh10);
  endproperty
  a_neutralSteps: assert property (p_neutralSteps) else $error("step offset wrong");

  // first edge after link reset still shows reset halves, so it is skipped
  property p_rxDdrHold;
    @(posedge rxRefClk) disable iff (linkRst)
      !$past(linkRst) |-> rxDataR == $past(rxDataRise) && rxDataF == $past(rxDataFall)
        && rxCtlR == $past(rxCtlRise) && rxCtlF == $past(rxCtlFall);
  endproperty
  a_rxDdrHold: assert property (p_rxDdrHold) else $error("ddr halves misaligned");

  property p_rdValidPulse;
    @(posedge core_clk) disable iff (rst)
      mgmtRdValid == $past(mgmtRdEn);
  endproperty
  a_rdValidPulse: assert property (p_rdValidPulse) else $error("read valid timing wrong");

  property p_ctrlWrite;
    @(posedge core_clk) disable iff (rst)
      s_ctrlWrite |=> portalCtrl == $past(mgmtWrData);
  endproperty
  a_ctrlWrite: assert property (p_ctrlWrite) else $error("portal control write lost");

  property p_addrWrite;
    @(posedge core_clk) disable iff (rst)
      s_addrWrite |=> portalAddr == $past(mgmtWrData);
  endproperty
  a_addrWrite: assert property (p_addrWrite) else $error("portal offset write lost");

  // no post-increment: data accesses leave the offset alone
  property p_addrHeld;
    @(posedge core_clk) disable iff (rst)
      s_dataWrite |=> $stable(portalAddr);
  endproperty
  a_addrHeld: assert property (p_addrHeld) else $error("portal offset moved");

  property p_ctrlReadBack;
    @(posedge core_clk) disable iff (rst)
      mgmtRdEn && mgmtAddr == REG_MMD_CTRL |=> mgmtRdData == $past(portalCtrl);
  endproperty
  a_ctrlReadBack: assert property (p_ctrlReadBack) else $error("portal control read wrong");

  property p_unknownReadZero;
    @(posedge core_clk) disable iff (rst)
      mgmtRdEn && mgmtAddr == REG_MMD_DATA && dataMode && !selKnown
      |=> mgmtRdData == 16'h0000;
  endproperty
  a_unknownReadZero: assert property (p_unknownReadZero) else $error("unknown offset read");

  property p_ctlWriteMasked;
    @(posedge core_clk) disable iff (rst)
      s_dataWrite ##0 portalAddr == OFS_CTL_SKEW
      |=> controlSignalSkew == ($past(mgmtWrData) & MASK_CTL_SKEW);
  endproperty
  a_ctlWriteMasked: assert property (p_ctlWriteMasked) else $error("control write wrong");

  property p_rxdWriteLands;
    @(posedge core_clk) disable iff (rst)
      s_dataWrite ##0 portalAddr == OFS_RXD_SKEW |=> receiveDataSkew == $past(mgmtWrData);
  endproperty
  a_rxdWriteLands: assert property (p_rxdWriteLands) else $error("rx data write lost");

  property p_txdWriteLands;
    @(posedge core_clk) disable iff (rst)
      s_dataWrite ##0 portalAddr == OFS_TXD_SKEW |=> transmitDataSkew == $past(mgmtWrData);
  endproperty
  a_txdWriteLands: assert property (p_txdWriteLands) else $error("tx data write lost");

  property p_bit3Reset;
    @(posedge rxRefClk)
      linkRst |=> rx_bit3_delay_code == RST_RXD_SKEW[15:12]
        && tx_bit3_delay_code == RST_TXD_SKEW[15:12];
  endproperty
  a_bit3Reset: assert property (p_bit3Reset) else $error("bit3 lane reset wrong");

  // just before an edge the pins still show the half of the phase that ends
  property p_rxRiseHalf;
    @(negedge rxRefClk)
      linkRst == 1'b0 |-> rxCtlPin == rxCtlR && rxDataPin == rxDataR;
  endproperty
  a_rxRiseHalf: assert property (p_rxRiseHalf) else $error("rise half not on pins");

  property p_rxFallHalf;
    @(posedge rxRefClk)
      linkRst == 1'b0 |-> rxCtlPin == rxCtlF && rxDataPin == rxDataF;
  endproperty
  a_rxFallHalf: assert property (p_rxFallHalf) else $error("fall half not on pins");
endmodule

// >>> verif/rpsk_mac_rx.sv
// receiving side model that captures the receive group on both clock edges
`timescale 1ns/1ps
module rpsk_mac_rx (
  input wire logic rxClk,
  input wire logic rxCtl,
  input wire logic [3:0] rxData,
  output logic [4:0] capRise,
  output logic [4:0] capFall
);
  // sample mid half-period, away from the pin mux switching point
  initial begin
    capRise = 5'h00;
    capFall = 5'h00;
  end
  always @(posedge rxClk) begin
    #12;
    capRise = {rxCtl, rxData};
  end
  always @(negedge rxClk) begin
    #12;
    capFall = {rxCtl, rxData};
  end
endmodule

// >>> verif/rpsk_pad_skew_tb.sv
// self-checking bench for the pad skew register bank
`timescale 1ns/1ps
module rpsk_pad_skew_tb;
  import rpsk_pkg::*;
  logic core_clk, rst, rxRefClk, mgmtWrEn, mgmtRdEn, mgmtRdValid, cfgBusy;
  logic [4:0] mgmtAddr;
  logic [15:0] mgmtWrData, mgmtRdData, rxDataDelayCodes, txDataDelayCodes;
  logic rxCtlRise, rxCtlFall, rxClkPin, rxCtlPin;
  logic [3:0] rxDataRise, rxDataFall, rxDataPin, rxCtlCode, txCtlCode;
  logic [4:0] txClkCode, rxClkCode, capRise, capFall;
  logic signed [5:0] rxClockSteps, txClockSteps;
  logic signed [4:0] rxCtlSteps;
  int errTotal = 0;
  int numChecks = 0;
  rpsk_pad_skew uut (.core_clk(core_clk), .rst(rst), .mgmtAddr(mgmtAddr),
    .mgmtWrEn(mgmtWrEn), .mgmtRdEn(mgmtRdEn), .mgmtWrData(mgmtWrData),
    .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid), .cfgBusy(cfgBusy),
    .rxRefClk(rxRefClk), .rxCtlRise(rxCtlRise), .rxCtlFall(rxCtlFall),
    .rxDataRise(rxDataRise), .rxDataFall(rxDataFall), .rxClkPin(rxClkPin),
    .rxCtlPin(rxCtlPin), .rxDataPin(rxDataPin), .rx_ctl_delay_code(rxCtlCode),
    .txCtlDelayCode(txCtlCode), .rxDataDelayCodes(rxDataDelayCodes),
    .txDataDelayCodes(txDataDelayCodes), .tx_clock_delay_code(txClkCode),
    .rxClockDelayCode(rxClkCode), .rxClockSteps(rxClockSteps),
    .txClockSteps(txClockSteps), .rxCtlSteps(rxCtlSteps));
  rpsk_mac_rx mac (.rxClk(rxClkPin), .rxCtl(rxCtlPin), .rxData(rxDataPin),
    .capRise(capRise), .capFall(capFall));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // link clock phase deliberately unrelated to the core clock
  initial begin
    rxRefClk = 1'b0;
    #7;
    forever #24 rxRefClk = ~rxRefClk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    mgmtAddr <= a;
    mgmtWrData <= d;
    mgmtWrEn <= 1'b1;
    @(posedge core_clk);
    mgmtWrEn <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string what);
    @(posedge core_clk);
    mgmtAddr <= a;
    mgmtRdEn <= 1'b1;
    @(posedge core_clk);
    mgmtRdEn <= 1'b0;
    #1;
    chk("rdValid", 16'h0001, {15'h0000, mgmtRdValid});
    chk(what, exp, mgmtRdData);
  endtask
  task automatic mmdWr(input logic [15:0] ofs, input logic [15:0] d, input logic [4:0] dev);
    wr(REG_MMD_CTRL, {11'h000, dev});
    wr(REG_MMD_DATA, ofs);
    wr(REG_MMD_CTRL, {11'h200, dev});
    wr(REG_MMD_DATA, d);
  endtask
  task automatic mmdRd(input logic [15:0] ofs, input logic [15:0] exp, input string what);
    wr(REG_MMD_CTRL, 16'h0002);
    wr(REG_MMD_DATA, ofs);
    wr(REG_MMD_CTRL, 16'h4002);
    rd(REG_MMD_DATA, exp, what);
  endtask
  // wait for delivery, bounded; a queued change raises busy again right after
  // it falls, so busy must stay low for several edges in a row
  task automatic settle();
    int n;
    int quiet;
    n = 0;
    quiet = 0;
    while (quiet < 3 && n < 80) begin
      @(posedge core_clk);
      #1;
      quiet = (cfgBusy === 1'b0) ? quiet + 1 : 0;
      n++;
    end
    chk("busyCleared", 16'h0000, {15'h0000, cfgBusy});
  endtask
  task automatic codes(input logic [15:0] c4, r5, r6, r8);
    chk("rxCtlCode", {12'h000, c4[7:4]}, {12'h000, rxCtlCode});
    chk("txCtlCode", {12'h000, c4[3:0]}, {12'h000, txCtlCode});
    chk("rxDataCodes", r5, rxDataDelayCodes);
    chk("txDataCodes", r6, txDataDelayCodes);
    chk("txClkCode", {11'h000, r8[9:5]}, {11'h000, txClkCode});
    chk("rxClkCode", {11'h000, r8[4:0]}, {11'h000, rxClkCode});
    chk("rxClkSteps", {10'h000, 6'(r8[4:0]) - 6'h0f}, {10'h000, rxClockSteps});
    chk("txClkSteps", {10'h000, 6'(r8[9:5]) - 6'h0f}, {10'h000, txClockSteps});
    chk("rxCtlSteps", {11'h000, 5'(c4[7:4]) - 5'h07}, {11'h000, rxCtlSteps});
  endtask
  task automatic link(input logic cr, cf, input logic [3:0] dr, df);
    @(posedge rxRefClk);
    rxCtlRise <= cr;
    rxCtlFall <= cf;
    rxDataRise <= dr;
    rxDataFall <= df;
    repeat (4) @(posedge rxRefClk);
    #20;
    chk("clkPin", {15'h0000, rxRefClk}, {15'h0000, rxClkPin});
    chk("riseHalf", {11'h000, cr, dr}, {11'h000, capRise});
    chk("fallHalf", {11'h000, cf, df}, {11'h000, capFall});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    errTotal++;
    $display("watchdog expired");
    conclude();
  end
  initial begin
    rst = 1'b1;
    mgmtAddr = 5'h00;
    mgmtWrEn = 1'b0;
    mgmtRdEn = 1'b0;
    mgmtWrData = 16'h0000;
    rxCtlRise = 1'b0;
    rxCtlFall = 1'b0;
    rxDataRise = 4'h0;
    rxDataFall = 4'h0;
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    codes(16'h0077, 16'h7777, 16'h7777, 16'h01ef);
    mmdRd(OFS_CTL_SKEW, 16'h0077, "reg4Reset");
    mmdRd(OFS_RXD_SKEW, 16'h7777, "reg5Reset");
    mmdRd(OFS_TXD_SKEW, 16'h7777, "reg6Reset");
    mmdRd(OFS_CLK_SKEW, 16'h01ef, "reg8Reset");
    $display("test reset values done");
    mmdWr(OFS_CLK_SKEW, 16'h03ff, 5'h02);
    settle();
    mmdRd(OFS_CLK_SKEW, 16'h03ff, "reg8Max");
    codes(16'h0077, 16'h7777, 16'h7777, 16'h03ff);
    mmdWr(OFS_CLK_SKEW, 16'hffff, 5'h02);
    settle();
    mmdRd(OFS_CLK_SKEW, 16'h03ff, "reg8Reserved");
    mmdWr(OFS_CLK_SKEW, 16'h0000, 5'h02);
    settle();
    codes(16'h0077, 16'h7777, 16'h7777, 16'h0000);
    $display("test clock codes done");
    mmdWr(OFS_CTL_SKEW, 16'hffff, 5'h02);
    mmdRd(OFS_CTL_SKEW, 16'h00ff, "reg4Reserved");
    // second and third changes each land eight core cycles later, after the previous one has crossed
    mmdWr(OFS_CTL_SKEW, 16'h00f0, 5'h02);
    mmdWr(OFS_RXD_SKEW, 16'h1234, 5'h02);
    mmdWr(OFS_TXD_SKEW, 16'hcdef, 5'h02);
    settle();
    codes(16'h00f0, 16'h1234, 16'hcdef, 16'h0000);
    mmdRd(OFS_RXD_SKEW, 16'h1234, "reg5");
    mmdRd(OFS_TXD_SKEW, 16'hcdef, "reg6");
    $display("test control and data codes done");
    mmdWr(OFS_CTL_SKEW, 16'h0012, 5'h03);
    mmdRd(OFS_CTL_SKEW, 16'h00f0, "otherDevice");
    mmdRd(16'h0007, 16'h0000, "unknownOffset");
    wr(REG_MMD_CTRL, 16'h0002);
    wr(REG_MMD_DATA, 16'h0008);
    rd(REG_MMD_DATA, 16'h0008, "offsetReadback");
    $display("test portal refusals done");
    link(1'b1, 1'b0, 4'ha, 4'h5);
    link(1'b0, 1'b1, 4'h3, 4'hc);
    $display("test receive pins done");
    conclude();
  end
endmodule
